// ---- config_unlock_control.v ----
// Purpose: Configuration gate on the host bus: unlock, lock, reload, menu, reset, version text
// Assumes: Host strobes come from logic on clk_sys, one cycle per access
// Notes: Read data and claim appear one cycle after the read strobe
// Behaviour
// - Command address reads all-ones unless configuration mode is active.
// - Writing 42 to the command register enters configuration mode.
// - Writing all-ones to the command register leaves configuration mode.
// - Any write to either neighbour address also leaves configuration mode.
// - In configuration mode the whole sixteen-byte setup range is decoded.
// - In configuration mode the command register reads the core configuration code.
// - After power-up the selected core slot is slot zero.
// - In configuration mode, 16 ored with slot number reloads from that slot.
// - In configuration mode, writing 32 switches the system into menu mode.
// - Writing 165 forces a system reset.
// - Writing 166 forces a system reset and leaves configuration mode.
// - Reset commands are ignored unless configuration or menu mode is active.
// - Version registers decode only while the map bit one is set.
// - Index register selects a character; value register returns it as ASCII.
// - Positions 0 to 7 hold core version text padded with spaces.
// - Positions 8 to 15 hold build date as YYYYMMDD digits.
// - Positions 16 to 255 are reserved and return any value.
`include "config_unlock_defs.vh"

module config_unlock_control #(
	parameter [63:0] VERSION_TEXT = "rev-0a  ",
	parameter [63:0] BUILD_DATE = "20000101"
) (
	input wire clk_sys,
	input wire rst,
	input wire [15:0] bus_addr,
	input wire [7:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	input wire [7:0] platform_code,
	input wire menu_leave,
	output reg [7:0] bus_rdata_q,
	output reg bus_claim_q,
	output reg config_mode_q,
	output reg menu_mode_q,
	output reg mmu_map_q,
	output reg [3:0] reload_slot_q,
	output reg reload_req_q,
	output reg sys_reset_q
);

// ==========================================================
// Decode
function in_cfg_page;
	input [15:0] a;
	begin
		in_cfg_page = ((a & `CFG_PAGE_MASK) == `ADDR_CFG_BASE);
	end
endfunction

// Match a host address against one register location
function addr_is;
	input [15:0] a;
	input [15:0] loc;
	begin
		addr_is = (a == loc);
	end
endfunction

// Slot reloads share one tag in the upper nibble, slot in the lower
function cmd_is_reload;
	input [7:0] d;
	begin
		cmd_is_reload = ((d & `CMD_RELOAD_MASK) == `CMD_RELOAD_TAG);
	end
endfunction

// ==========================================================
// State and next values
reg [7:0] map_cfg_q;
reg [7:0] map_cfg_d;
reg [7:0] ver_index_q;
reg [7:0] ver_index_d;
reg config_mode_d;
reg menu_mode_d;
reg mmu_map_d;
reg [3:0] reload_slot_d;
reg reload_req_d;
reg sys_reset_d;
reg [7:0] bus_rdata_d;
reg bus_claim_d;
wire [7:0] ver_char;

// ==========================================================
// Address hits
wire map_on = map_cfg_q[`MAP_MMU_BIT];
wire cfg_hit = config_mode_q && in_cfg_page(bus_addr);
wire cmd_hit = cfg_hit && addr_is(bus_addr, `ADDR_CMD);
wire map_hit = cfg_hit && addr_is(bus_addr, `ADDR_MAP_CFG);
wire ver_idx_hit = map_on && addr_is(bus_addr, `ADDR_VER_INDEX);
wire ver_val_hit = map_on && addr_is(bus_addr, `ADDR_VER_VALUE);
// The command address takes writes while locked too, or unlock could never land
wire cmd_wr = bus_wr && addr_is(bus_addr, `ADDR_CMD);
// Exit addresses only act while unlocked; when locked they belong to the mirror
wire exit_wr = bus_wr && config_mode_q &&
	(addr_is(bus_addr, `ADDR_EXIT_LO) || addr_is(bus_addr, `ADDR_EXIT_HI));
wire reset_ok = config_mode_q || menu_mode_q;

// ==========================================================
// Command decode
// One-hot, so each command value maps to exactly one action
localparam [6:0] OP_NONE = 7'h01;
localparam [6:0] OP_UNLOCK = 7'h02;
localparam [6:0] OP_LOCK = 7'h04;
localparam [6:0] OP_RESET = 7'h08;
localparam [6:0] OP_RESET_LOCK = 7'h10;
localparam [6:0] OP_RELOAD = 7'h20;
localparam [6:0] OP_MENU = 7'h40;
reg [6:0] cmd_op;

always @* begin
	cmd_op = OP_NONE;
	if (cmd_wr) begin
		if (bus_wdata == `CMD_UNLOCK) begin
			cmd_op = OP_UNLOCK;
		end else if (bus_wdata == `CMD_LOCK) begin
			cmd_op = OP_LOCK;
		end else if (bus_wdata == `CMD_RESET) begin
			cmd_op = OP_RESET;
		end else if (bus_wdata == `CMD_RESET_LOCK) begin
			cmd_op = OP_RESET_LOCK;
		end else if (config_mode_q && cmd_is_reload(bus_wdata)) begin
			cmd_op = OP_RELOAD;
		end else if (config_mode_q && (bus_wdata == `CMD_MENU)) begin
			cmd_op = OP_MENU;
		end
	end
end

version_rom #(
	.VERSION_TEXT(VERSION_TEXT),
	.BUILD_DATE(BUILD_DATE)
) u_version_rom (
	.index(ver_index_q),
	.char_out(ver_char)
);

// ==========================================================
// Mode and command handling
// Reload and reset are one-cycle pulses; the loader and reset logic latch them
always @* begin
	config_mode_d = config_mode_q;
	menu_mode_d = menu_mode_q;
	reload_slot_d = reload_slot_q;
	reload_req_d = 1'b0;
	sys_reset_d = 1'b0;
	// Leave is applied first so a menu command in the same cycle wins
	if (menu_leave) begin
		menu_mode_d = 1'b0;
	end
	if (exit_wr) begin
		config_mode_d = 1'b0;
	end
	case (cmd_op)
		OP_UNLOCK: begin
			config_mode_d = 1'b1;
		end
		OP_LOCK: begin
			config_mode_d = 1'b0;
		end
		OP_RESET: begin
			if (reset_ok) begin
				sys_reset_d = 1'b1;
			end
		end
		OP_RESET_LOCK: begin
			if (reset_ok) begin
				sys_reset_d = 1'b1;
				config_mode_d = 1'b0;
			end
		end
		OP_RELOAD: begin
			reload_slot_d = bus_wdata[`SLOT_LSB +: `SLOT_W];
			reload_req_d = 1'b1;
		end
		OP_MENU: begin
			menu_mode_d = 1'b1;
		end
		default: begin
			reload_req_d = 1'b0;
		end
	endcase
end

// ==========================================================
// Mode registers
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		config_mode_q <= 1'b0;
		menu_mode_q <= 1'b0;
		reload_slot_q <= `BOOT_SLOT;
		reload_req_q <= 1'b0;
		sys_reset_q <= 1'b0;
	end else begin
		config_mode_q <= config_mode_d;
		menu_mode_q <= menu_mode_d;
		reload_slot_q <= reload_slot_d;
		reload_req_q <= reload_req_d;
		sys_reset_q <= sys_reset_d;
	end
end

// ==========================================================
// Setup and version registers
// The map bit outlives configuration mode, so version reads work after locking
always @* begin
	map_cfg_d = map_cfg_q;
	mmu_map_d = mmu_map_q;
	ver_index_d = ver_index_q;
	if (bus_wr && map_hit) begin
		map_cfg_d = bus_wdata;
		mmu_map_d = bus_wdata[`MAP_MMU_BIT];
	end
	if (bus_wr && ver_idx_hit) begin
		ver_index_d = bus_wdata;
	end
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		map_cfg_q <= `MAP_CFG_RESET;
		ver_index_q <= `VER_INDEX_RESET;
		mmu_map_q <= 1'b0;
	end else begin
		map_cfg_q <= map_cfg_d;
		ver_index_q <= ver_index_d;
		mmu_map_q <= mmu_map_d;
	end
end

// ==========================================================
// Read source select
// One-hot source code keeps the data mux a flat case
localparam [5:0] SRC_NONE = 6'h01;
localparam [5:0] SRC_CODE = 6'h02;
localparam [5:0] SRC_MAP = 6'h04;
localparam [5:0] SRC_ZERO = 6'h08;
localparam [5:0] SRC_INDEX = 6'h10;
localparam [5:0] SRC_CHAR = 6'h20;
reg [5:0] rd_src;

always @* begin
	rd_src = SRC_NONE;
	if (bus_rd) begin
		if (cmd_hit) begin
			rd_src = SRC_CODE;
		end else if (map_hit) begin
			rd_src = SRC_MAP;
		end else if (cfg_hit) begin
			rd_src = SRC_ZERO;
		end else if (ver_idx_hit) begin
			rd_src = SRC_INDEX;
		end else if (ver_val_hit) begin
			rd_src = SRC_CHAR;
		end
	end
end

// ==========================================================
// Read path
// Unclaimed reads return all-ones so the bus looks like an empty mirror
always @* begin
	case (rd_src)
		SRC_CODE: begin
			bus_rdata_d = platform_code;
			bus_claim_d = 1'b1;
		end
		SRC_MAP: begin
			bus_rdata_d = map_cfg_q;
			bus_claim_d = 1'b1;
		end
		SRC_ZERO: begin
			bus_rdata_d = `DATA_ZERO;
			bus_claim_d = 1'b1;
		end
		SRC_INDEX: begin
			bus_rdata_d = ver_index_q;
			bus_claim_d = 1'b1;
		end
		SRC_CHAR: begin
			bus_rdata_d = ver_char;
			bus_claim_d = 1'b1;
		end
		default: begin
			bus_rdata_d = `DATA_ALL_ONES;
			bus_claim_d = 1'b0;
		end
	endcase
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		bus_rdata_q <= `DATA_ALL_ONES;
		bus_claim_q <= 1'b0;
	end else begin
		bus_rdata_q <= bus_rdata_d;
		bus_claim_q <= bus_claim_d;
	end
end

endmodule

// ---- config_unlock_control_props.sv ----
// Purpose: Port assertions for the configuration gate
// Assumes: One clock, asynchronous active-high reset
// Notes: Attached to the gate by the bind at the foot
module config_unlock_control_props (
	input wire clk_sys, rst, bus_wr, bus_rd, menu_leave,
	input wire [15:0] bus_addr,
	input wire [7:0] bus_wdata, platform_code, bus_rdata_q,
	input wire bus_claim_q, config_mode_q, menu_mode_q, mmu_map_q,
	input wire [3:0] reload_slot_q,
	input wire reload_req_q, sys_reset_q
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire cw = bus_wr && bus_addr == 16'hd0fe;
	wire cr = bus_rd && bus_addr == 16'hd0fe;
	unlock_enter_a: assert property (cw && bus_wdata == 8'h2a |=> config_mode_q)
		else $error("unlock ignored");
	lock_leave_a: assert property (cw && bus_wdata == 8'hff |=> !config_mode_q)
		else $error("lock ignored");
	exit_write_a: assert property (bus_wr && (bus_addr == 16'hd0fd || bus_addr == 16'hd0ff)
		|=> !config_mode_q) else $error("exit write ignored");
	locked_read_a: assert property (cr && !config_mode_q |=> bus_rdata_q == 8'hff)
		else $error("locked read not all ones");
	code_read_a: assert property (cr && config_mode_q
		|=> bus_claim_q && bus_rdata_q == $past(platform_code)) else $error("bad code read");
	slot_reload_a: assert property (cw && config_mode_q && bus_wdata[7:4] == 4'h1
		|=> reload_req_q && reload_slot_q == $past(bus_wdata[3:0])) else $error("bad reload");
	menu_enter_a: assert property (cw && config_mode_q && bus_wdata == 8'h20 |=> menu_mode_q)
		else $error("menu not entered");
	reset_gate_a: assert property (cw && (bus_wdata == 8'ha5 || bus_wdata == 8'ha6)
		&& !config_mode_q && !menu_mode_q |=> !sys_reset_q) else $error("reset not gated");
	reset_exit_a: assert property (cw && config_mode_q && bus_wdata == 8'ha6
		|=> sys_reset_q && !config_mode_q) else $error("reset exit failed");
	cover property (cr && config_mode_q);
	cover property (reload_req_q);
	cover property (sys_reset_q && menu_mode_q);
endmodule
bind config_unlock_control config_unlock_control_props i_props (.*);

// ---- config_unlock_control_test.sv ----
// Purpose: Self-checking bench for the configuration gate
// Assumes: Reads are scored one cycle after their strobe
// Notes: Platform code and reload slot come from a fixed seed
module config_unlock_control_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam [63:0] VT = "core-7  ";
	localparam [63:0] BD = "19990615";
	logic clk_sys = 0, rst = 1, menu_leave = 0, rd_p = 0;
	logic [7:0] platform_code = 8'h00, v;
	wire [15:0] bus_addr;
	wire [7:0] bus_wdata, bus_rdata_q;
	wire bus_wr, bus_rd, bus_claim_q, config_mode_q, menu_mode_q, mmu_map_q;
	wire reload_req_q, sys_reset_q;
	wire [3:0] reload_slot_q;
	int failures = 0, num_checks = 0, seed = 99032;
	logic [8:0] notes[$];
	host_cpu_model i_host_cpu_model (.*);
	config_unlock_control #(.VERSION_TEXT(VT), .BUILD_DATE(BD)) i_config_unlock_control (.*);
	initial forever #12.5 clk_sys = ~clk_sys;
	task chk(input logic [8:0] s, input logic [8:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task close_out;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		i_host_cpu_model.access(a, d, 1'b1);
	endtask
	task rd(input logic [15:0] a, input logic [8:0] e);
		notes.push_back(e);
		i_host_cpu_model.access(a, 8'h00, 1'b0);
	endtask
	// Claim and data are scored together against the oldest note
	always @(posedge clk_sys) rd_p <= bus_rd;
	always @(negedge clk_sys)
		if (rd_p)
			chk({bus_claim_q, bus_rdata_q}, notes.pop_front());
	initial begin
		platform_code = $random(seed);
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 0;
		chk(9'(reload_slot_q), 9'h000);
		rd(16'hd0fe, 9'h0ff);
		wr(16'hd0fe, 8'h2a);
		rd(16'hd0fe, {1'b1, platform_code});
		wr(16'hd0fe, 8'hff);
		rd(16'hd0fa, 9'h0ff);
		wr(16'hd0fe, 8'h13);
		chk(9'({reload_req_q, reload_slot_q}), 9'h000);
		wr(16'hd0fe, 8'h20);
		chk(9'(menu_mode_q), 9'h000);
		wr(16'hd0fe, 8'ha5);
		chk(9'(sys_reset_q), 9'h000);
		wr(16'hd0fe, 8'h2a);
		rd(16'hd0a9, 9'h0ff);
		wr(16'hd0fa, 8'h02);
		chk(9'(mmu_map_q), 9'h001);
		rd(16'hd0fa, 9'h102);
		for (int i = 0; i < 16; i++) begin
			wr(16'hd0a8, i[7:0]);
			v = i < 8 ? VT[63 - 8 * i -: 8] : BD[127 - 8 * i -: 8];
			rd(16'hd0a9, {1'b1, v});
		end
		v = $random(seed);
		wr(16'hd0fe, {4'h1, v[3:0]});
		chk(9'({reload_req_q, reload_slot_q}), 9'({1'b1, v[3:0]}));
		wr(16'hd0fd, 8'h00);
		chk(9'(config_mode_q), 9'h000);
		wr(16'hd0fe, 8'h2a);
		wr(16'hd0fe, 8'h20);
		chk(9'(menu_mode_q), 9'h001);
		wr(16'hd0ff, 8'h5a);
		wr(16'hd0fe, 8'ha5);
		chk(9'({sys_reset_q, config_mode_q}), 9'h002);
		@(negedge clk_sys);
		menu_leave = 1;
		@(negedge clk_sys);
		menu_leave = 0;
		wr(16'hd0fe, 8'h2a);
		wr(16'hd0fe, 8'ha6);
		chk(9'({sys_reset_q, config_mode_q, menu_mode_q}), 9'h004);
		close_out;
	end
	initial begin
		#(25 * 1000);
		failures++;
		close_out;
	end
endmodule

// ---- config_unlock_defs.vh ----
// Purpose: Shared constants for the configuration gate and version string ROM
// Assumes: 16-bit host address bus, 8-bit data
// Notes: Definitions only
`ifndef CONFIG_UNLOCK_DEFS_VH
`define CONFIG_UNLOCK_DEFS_VH

// ==========================================================
// Addresses
`define ADDR_CMD 16'hd0fe
`define ADDR_EXIT_LO 16'hd0fd
`define ADDR_EXIT_HI 16'hd0ff
`define ADDR_MAP_CFG 16'hd0fa
`define ADDR_CFG_BASE 16'hd0f0
`define CFG_PAGE_MASK 16'hfff0
`define ADDR_VER_INDEX 16'hd0a8
`define ADDR_VER_VALUE 16'hd0a9

// ==========================================================
// Command values
`define CMD_UNLOCK 8'h2a
`define CMD_LOCK 8'hff
`define CMD_MENU 8'h20
`define CMD_RESET 8'ha5
`define CMD_RESET_LOCK 8'ha6
`define CMD_RELOAD_MASK 8'hf0
`define CMD_RELOAD_TAG 8'h10

// ==========================================================
// Fields and reset values
`define MAP_MMU_BIT 1
`define SLOT_LSB 0
`define SLOT_W 4
`define BOOT_SLOT 4'h0
`define DATA_ALL_ONES 8'hff
`define DATA_ZERO 8'h00
`define MAP_CFG_RESET 8'h00
`define VER_INDEX_RESET 8'h00
`define ASCII_SPACE 8'h20
`define VER_TEXT_LEN 8
`define CHAR_W 8
`define VER_DATE_LAST 15

`endif

// ---- host_cpu_model.sv ----
// Purpose: Host processor side of the bus, one access per task call
// Assumes: Strobes launched on the falling edge, held over one rising edge
// Notes: Released address and data lines show the inverse of their last value; both strobes return low
module host_cpu_model (
	input wire clk_sys,
	output logic [15:0] bus_addr,
	output logic [7:0] bus_wdata,
	output logic bus_wr,
	output logic bus_rd
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		bus_addr = 16'h0000;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	end
	task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w);
		@(negedge clk_sys);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = w;
		bus_rd = !w;
		@(negedge clk_sys);
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = ~a;
		bus_wdata = ~d;
	endtask
endmodule

// ---- version_rom.v ----
// Purpose: Returns one ASCII character of the core version text or build date
// Assumes: Index from the version character index register
// Notes: Combinational lookup; strings are parameters so builds can stamp them
`include "config_unlock_defs.vh"

module version_rom #(
	// Eight characters, first character in the top byte; arbitrary default
	parameter [63:0] VERSION_TEXT = "rev-0a  ",
	// Eight ASCII digits YYYYMMDD, first digit in the top byte; arbitrary default
	parameter [63:0] BUILD_DATE = "20000101"
) (
	input wire [7:0] index,
	output reg [7:0] char_out
);

// ==========================================================
// Lookup
function [7:0] pick_byte;
	input [63:0] text;
	input [2:0] pos;
	begin
		pick_byte = text[(`VER_TEXT_LEN - 1 - pos) * `CHAR_W +: `CHAR_W];
	end
endfunction

always @* begin
	if (index < `VER_TEXT_LEN) begin
		// Space padding is carried in the parameter itself
		char_out = pick_byte(VERSION_TEXT, index[2:0]);
	end else if (index <= `VER_DATE_LAST) begin
		char_out = pick_byte(BUILD_DATE, index[2:0]);
	end else begin
		// Undefined positions give a space so displays stay tidy
		char_out = `ASCII_SPACE;
	end
end

endmodule
